// File: hw/motor_start_supervision.sv
`timescale 1ns/1ps
`include "motor_start_supervision_params.svh"
// Operation
// - Motor is stopped whenever average current is below 10% of nominal.
// - Starting needs at least 500 ms continuously stopped beforehand.
// - Starting needs current above start level within 200 ms of leaving stop.
// - Starting holds until the running conditions are met.
// - Running entered from stopped or starting with current in 20..120% nominal.
// - Starting and running are separate outputs for the output matrix.
// - Slow current rise goes stopped to running with no start indication.
// - Start detection level defaults to six times nominal and is writable.
// - A start is counted when current below 10% later exceeds start level.
// - After a counted start, current below 10% means motor stopped again.
// - Alarm on second-to-last allowed start, until maximum reached or hour passes.
// - Inhibit after each start for the minimum interval, then released.
// - Inhibit while starts in the hour reach the maximum.
// - One force flag for all outputs, cleared five minutes after last key.
// - Readable starts in last hour and minutes since last start.
// - Record trip time, starts per hour, time since start, total starts.
module motor_start_supervision
    import motor_start_supervision_pkg::*;
#(
    parameter int CYCLES_PER_MS = `CLOCK_HZ / `MS_PER_SEC,
    parameter int HOUR_MS = `HOUR_MS,
    parameter int MINUTE_MS = `MINUTE_MS,
    parameter int FORCE_MS = `FORCE_TIMEOUT_MS,
    parameter int MAX_SLOTS = 15
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [15:0] avgCurrent,
    input wire logic keyPress,
    input wire logic [31:0] timeNow,
    output logic startingOut,
    output logic runningOut,
    output logic alarmOut,
    output logic inhibitOut,
    output logic irq
);

    localparam int STOP_HOLD_MS = `STOP_HOLD_MS;
    localparam int RISE_WINDOW_MS = `RISE_WINDOW_MS;

    settings_s setFf;
    motor_state_e stateFf, nxt_state;
    logic [31:0] msCntFf, ageFf [MAX_SLOTS], minSubFf, forceMsFf;
    logic msTickFf, armedFf, fsArmedFf, everStartedFf, forceFf;
    logic [9:0] stopMsFf, riseMsFf;
    logic validFf [MAX_SLOTS];
    logic [15:0] sinceMinFf;
    logic [31:0] totalFf, tripTimeFf;
    logic [7:0] tripCntFf;
    logic [15:0] tripSinceFf;
    logic [3:0] forceValFf, irqStatusFf, irqEnableFf;
    logic alarmRawFf, inhibitRawFf;
    logic [31:0] cur100, nomStop, nomRunLo, nomRunHi, nomStart;
    logic lowNow, runBand, aboveStart, startEvt, alarmNow, inhibitNow;
    logic [7:0] startsInHour;
    logic [3:0] freeSlot;
    logic freeFound;
    logic busAccept, ctrlWrite;
    events_s evt;

    // Scaled compares avoid a divider on the current path
    assign cur100 = {16'h0000, avgCurrent} * 32'd`PCT_SCALE;
    assign nomStop = {16'h0000, setFf.nominal} * 32'd`STOP_PCT;
    assign nomRunLo = {16'h0000, setFf.nominal} * 32'd`RUN_LOW_PCT;
    assign nomRunHi = {16'h0000, setFf.nominal} * 32'd`RUN_HIGH_PCT;
    assign nomStart = {16'h0000, setFf.nominal} * {16'h0000, setFf.startDetectLevel};
    assign lowNow = cur100 < nomStop;
    assign runBand = (cur100 >= nomRunLo) && (cur100 <= nomRunHi);
    assign aboveStart = cur100 > nomStart;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            msCntFf <= 32'h0;
            msTickFf <= 1'b0;
        end else if (msCntFf == 32'(CYCLES_PER_MS - 1)) begin
            msCntFf <= 32'h0;
            msTickFf <= 1'b1;
        end else begin
            msCntFf <= msCntFf + 32'h1;
            msTickFf <= 1'b0;
        end
    end

    // Stop duration and rise window, both in milliseconds
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stopMsFf <= 10'h0;
            riseMsFf <= 10'h0;
            armedFf <= 1'b0;
        end else if (lowNow) begin
            riseMsFf <= 10'h0;
            armedFf <= stopMsFf >= 10'(STOP_HOLD_MS);
            if (msTickFf && stopMsFf < 10'(STOP_HOLD_MS))
                stopMsFf <= stopMsFf + 10'h1;
        end else begin
            stopMsFf <= 10'h0;
            if (msTickFf && riseMsFf < 10'(RISE_WINDOW_MS))
                riseMsFf <= riseMsFf + 10'h1;
        end
    end

    always_comb begin
        nxt_state = stateFf;
        case (stateFf)
            ST_STOPPED: begin
                if (armedFf && riseMsFf < 10'(RISE_WINDOW_MS) && aboveStart)
                    nxt_state = ST_STARTING;
                else if (runBand && riseMsFf >= 10'(RISE_WINDOW_MS))
                    nxt_state = ST_RUNNING;
            end
            ST_STARTING: begin
                if (runBand)
                    nxt_state = ST_RUNNING;
            end
            ST_RUNNING: nxt_state = ST_RUNNING;
            default: nxt_state = ST_STOPPED;
        endcase
        if (lowNow)
            nxt_state = ST_STOPPED;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            stateFf <= ST_STOPPED;
        else
            stateFf <= nxt_state;
    end

    // Frequent-start detection re-arms only below the stop level
    assign startEvt = fsArmedFf && aboveStart;
    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            fsArmedFf <= 1'b0;
        else if (lowNow)
            fsArmedFf <= 1'b1;
        else if (startEvt)
            fsArmedFf <= 1'b0;
    end

    // A start lost to a full window is acceptable: inhibit already blocks closing
    always_comb begin
        freeSlot = 4'h0;
        freeFound = 1'b0;
        startsInHour = 8'h0;
        for (int i = MAX_SLOTS - 1; i >= 0; i--) begin
            if (!validFf[i]) begin
                freeSlot = 4'(i);
                freeFound = 1'b1;
            end
            startsInHour = startsInHour + {7'h0, validFf[i]};
        end
    end

    for (genvar g = 0; g < MAX_SLOTS; g++) begin : gSlot
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                validFf[g] <= 1'b0;
                ageFf[g] <= 32'h0;
            end else if (startEvt && freeFound && freeSlot == 4'(g)) begin
                validFf[g] <= 1'b1;
                ageFf[g] <= 32'h0;
            end else if (validFf[g] && msTickFf) begin
                if (ageFf[g] == 32'(HOUR_MS - 1))
                    validFf[g] <= 1'b0;
                else
                    ageFf[g] <= ageFf[g] + 32'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            minSubFf <= 32'h0;
            sinceMinFf <= 16'h0;
            everStartedFf <= 1'b0;
            totalFf <= 32'h0;
        end else if (startEvt) begin
            minSubFf <= 32'h0;
            sinceMinFf <= 16'h0;
            everStartedFf <= 1'b1;
            totalFf <= totalFf + 32'h1;
        end else if (msTickFf) begin
            if (minSubFf == 32'(MINUTE_MS - 1)) begin
                minSubFf <= 32'h0;
                if (sinceMinFf != 16'hffff)
                    sinceMinFf <= sinceMinFf + 16'h1;
            end else begin
                minSubFf <= minSubFf + 32'h1;
            end
        end
    end

    assign alarmNow = (setFf.maxStarts != 4'h0) && ({4'h0, setFf.maxStarts} == startsInHour + 8'h1);
    assign inhibitNow = (everStartedFf && sinceMinFf < {8'h0, setFf.intervalMin})
                     || (setFf.maxStarts != 4'h0 && startsInHour >= {4'h0, setFf.maxStarts});

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            alarmRawFf <= 1'b0;
            inhibitRawFf <= 1'b0;
        end else begin
            alarmRawFf <= alarmNow;
            inhibitRawFf <= inhibitNow;
        end
    end

    assign evt.alarmOn = alarmNow && !alarmRawFf;
    assign evt.alarmOff = !alarmNow && alarmRawFf;
    assign evt.inhibitOn = inhibitNow && !inhibitRawFf;
    assign evt.inhibitOff = !inhibitNow && inhibitRawFf;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tripTimeFf <= 32'h0;
            tripCntFf <= 8'h0;
            tripSinceFf <= 16'h0;
        end else if (evt.inhibitOn) begin
            tripTimeFf <= timeNow;
            tripCntFf <= startsInHour;
            tripSinceFf <= sinceMinFf;
        end
    end

    // Bus slave: one wait cycle, then a single answer cycle
    assign busAccept = (read || write) && !waitrequest;
    assign ctrlWrite = busAccept && write && address == `REG_CTRL;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else if (busAccept || !(read || write)) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= 1'b0;
            if (address == `REG_CTRL)
                readdata <= {27'h0, forceValFf, forceFf};
            else if (address == `REG_NOMINAL)
                readdata <= {16'h0, setFf.nominal};
            else if (address == `REG_START_LEVEL)
                readdata <= {16'h0, setFf.startDetectLevel};
            else if (address == `REG_MAX_STARTS)
                readdata <= {28'h0, setFf.maxStarts};
            else if (address == `REG_INTERVAL)
                readdata <= {24'h0, setFf.intervalMin};
            else if (address == `REG_STATUS)
                readdata <= {sinceMinFf, startsInHour, 3'h0, inhibitRawFf, alarmRawFf, stateFf};
            else if (address == `REG_TOTAL)
                readdata <= totalFf;
            else if (address == `REG_TRIP_TIME)
                readdata <= tripTimeFf;
            else if (address == `REG_TRIP_REC)
                readdata <= {tripSinceFf, 8'h0, tripCntFf};
            else if (address == `REG_IRQ_STATUS)
                readdata <= {28'h0, irqStatusFf};
            else if (address == `REG_IRQ_ENABLE)
                readdata <= {28'h0, irqEnableFf};
            else
                readdata <= 32'h0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            setFf.nominal <= `RST_NOMINAL;
            setFf.startDetectLevel <= `RST_START_LEVEL;
            setFf.maxStarts <= `RST_MAX_STARTS;
            setFf.intervalMin <= `RST_INTERVAL;
            irqEnableFf <= 4'h0;
        end else if (busAccept && write) begin
            if (address == `REG_NOMINAL)
                setFf.nominal <= writedata[15:0];
            else if (address == `REG_START_LEVEL)
                setFf.startDetectLevel <= writedata[15:0];
            else if (address == `REG_MAX_STARTS)
                setFf.maxStarts <= writedata[3:0];
            else if (address == `REG_INTERVAL)
                setFf.intervalMin <= writedata[7:0];
            else if (address == `REG_IRQ_ENABLE)
                irqEnableFf <= writedata[3:0];
        end
    end

    // Force flag: a write that sets it wins over the timeout in the same cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            forceFf <= 1'b0;
            forceValFf <= 4'h0;
            forceMsFf <= 32'h0;
        end else begin
            if (keyPress)
                forceMsFf <= 32'h0;
            else if (msTickFf && forceMsFf < 32'(FORCE_MS))
                forceMsFf <= forceMsFf + 32'h1;
            if (ctrlWrite) begin
                forceFf <= writedata[`CTRL_FORCE_BIT];
                forceValFf <= writedata[`CTRL_FVAL_LSB +: 4];
            end else if (forceMsFf >= 32'(FORCE_MS)) begin
                forceFf <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            startingOut <= 1'b0;
            runningOut <= 1'b0;
            alarmOut <= 1'b0;
            inhibitOut <= 1'b0;
        end else if (forceFf) begin
            {inhibitOut, alarmOut, runningOut, startingOut} <= forceValFf;
        end else begin
            startingOut <= stateFf == ST_STARTING;
            runningOut <= stateFf == ST_RUNNING;
            alarmOut <= alarmNow;
            inhibitOut <= inhibitNow;
        end
    end

    // Sticky events: a new event beats a clear in the same cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irqStatusFf <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (busAccept && write && address == `REG_IRQ_CLEAR)
                irqStatusFf <= (irqStatusFf & ~writedata[3:0]) | evt;
            else
                irqStatusFf <= irqStatusFf | evt;
            irq <= |(irqStatusFf & irqEnableFf);
        end
    end

    a_stop_forced: assert property (@(posedge clock) disable iff (reset)
        lowNow |=> stateFf == ST_STOPPED)
        else $error("Low current did not stop the motor");

    a_start_entry: assert property (@(posedge clock) disable iff (reset)
        $rose(stateFf == ST_STARTING) |-> $past(armedFf) && $past(riseMsFf) < 10'(RISE_WINDOW_MS))
        else $error("Starting entered without hold or outside rise window");

    a_starting_hold: assert property (@(posedge clock) disable iff (reset)
        (stateFf == ST_STARTING && !runBand && !lowNow) |=> stateFf == ST_STARTING)
        else $error("Starting left without running conditions");

    a_run_entry: assert property (@(posedge clock) disable iff (reset)
        $rose(stateFf == ST_RUNNING) |-> $past(runBand) && !$past(lowNow))
        else $error("Running entered outside current band");

    a_soft_start: assert property (@(posedge clock) disable iff (reset)
        (stateFf == ST_STOPPED && !armedFf) |=> stateFf != ST_STARTING)
        else $error("Start signalled without a qualified stop");

    a_start_total: assert property (@(posedge clock) disable iff (reset)
        startEvt |=> totalFf == $past(totalFf) + 32'h1 && sinceMinFf == 16'h0)
        else $error("Start not counted");

    a_inhibit_max: assert property (@(posedge clock) disable iff (reset)
        (!forceFf && setFf.maxStarts != 4'h0 && startsInHour >= {4'h0, setFf.maxStarts}) ##1 !forceFf
        |-> inhibitOut)
        else $error("Inhibit missing at start maximum");

    a_alarm_follow: assert property (@(posedge clock) disable iff (reset)
        (!forceFf && alarmNow) ##1 !forceFf |-> alarmOut)
        else $error("Alarm missing on second-to-last start");

    a_event_sticky: assert property (@(posedge clock) disable iff (reset)
        evt.inhibitOn |=> irqStatusFf[`EVT_INHIBIT_ON])
        else $error("Inhibit event not latched");

    a_force_timeout: assert property (@(posedge clock) disable iff (reset)
        (forceMsFf >= 32'(FORCE_MS) && !ctrlWrite) |=> !forceFf)
        else $error("Force flag not cleared on timeout");

    a_bus_answer: assert property (@(posedge clock) disable iff (reset)
        ((read || write) && waitrequest) |=> !waitrequest)
        else $error("Bus answer late");

endmodule

// File: hw/motor_start_supervision_params.svh
`ifndef MOTOR_START_SUPERVISION_PARAMS_SVH
`define MOTOR_START_SUPERVISION_PARAMS_SVH

// Timebase
`define CLOCK_HZ 250000000
`define MS_PER_SEC 1000
`define STOP_HOLD_MS 500
`define RISE_WINDOW_MS 200
`define HOUR_MS 3600000
`define MINUTE_MS 60000
`define FORCE_TIMEOUT_MS 300000

// Current thresholds, percent of nominal
`define STOP_PCT 10
`define RUN_LOW_PCT 20
`define RUN_HIGH_PCT 120
`define PCT_SCALE 100

// Register byte offsets
`define REG_CTRL 6'h00
`define REG_NOMINAL 6'h04
`define REG_START_LEVEL 6'h08
`define REG_MAX_STARTS 6'h0c
`define REG_INTERVAL 6'h10
`define REG_STATUS 6'h14
`define REG_TOTAL 6'h18
`define REG_TRIP_TIME 6'h1c
`define REG_TRIP_REC 6'h20
`define REG_IRQ_STATUS 6'h24
`define REG_IRQ_CLEAR 6'h28
`define REG_IRQ_ENABLE 6'h2c

// Field positions
`define CTRL_FORCE_BIT 0
`define CTRL_FVAL_LSB 1
`define STATUS_CNT_LSB 8
`define STATUS_SINCE_LSB 16
`define EVT_ALARM_ON 0
`define EVT_ALARM_OFF 1
`define EVT_INHIBIT_ON 2
`define EVT_INHIBIT_OFF 3

// Reset values
`define RST_NOMINAL 16'h0064
`define RST_START_LEVEL 16'h0258
`define RST_MAX_STARTS 4'h3
`define RST_INTERVAL 8'h0a

`endif

// File: hw/motor_start_supervision_pkg.sv
package motor_start_supervision_pkg;

    typedef enum logic [2:0] {
        ST_STOPPED  = 3'b001,
        ST_STARTING = 3'b010,
        ST_RUNNING  = 3'b100
    } motor_state_e;

    typedef struct packed {
        logic [15:0] nominal;
        logic [15:0] startDetectLevel;
        logic [3:0] maxStarts;
        logic [7:0] intervalMin;
    } settings_s;

    typedef struct packed {
        logic inhibitOff;
        logic inhibitOn;
        logic alarmOff;
        logic alarmOn;
    } events_s;

endpackage

// File: sim/motor_front_model.sv
`timescale 1ns/1ps
// Current front end plus the output matrix that listens to the start indication
module motor_front_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic [15:0] target,
    input wire logic slow,
    input wire logic startingOut,
    output logic [15:0] avgCurrent,
    output logic [7:0] startSeen
);
    logic [3:0] div_ff;
    logic lastStart_ff;
    // Slow mode mimics a soft starter: one unit per 16 cycles, stopping at target (100 in the test, below the start level)
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            avgCurrent <= 16'h0000;
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
            if (!slow) begin
                avgCurrent <= target;
            end else if (div_ff == 4'hf && avgCurrent < target) begin
                avgCurrent <= avgCurrent + 16'h0001;
            end
        end
    end
    // Matrix side counts each rising start indication it receives
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lastStart_ff <= 1'b0;
            startSeen <= 8'h00;
        end else begin
            lastStart_ff <= startingOut;
            if (startingOut && !lastStart_ff) begin
                startSeen <= startSeen + 8'h01;
            end
        end
    end
endmodule

// File: sim/motor_start_supervision_tb.sv
`timescale 1ns/1ps
`include "motor_start_supervision_params.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_count++; \
    $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module motor_start_supervision_tb;
    logic clock, reset, read, write, keyPress, slow, waitrequest, irq;
    logic startingOut, runningOut, alarmOut, inhibitOut;
    logic [5:0] address;
    logic [31:0] writedata, readdata, timeNow, rd;
    logic [15:0] avgCurrent, target;
    logic [7:0] startSeen;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    int t3 = 0;

    // Scaled: 1 ms = 4 cycles, hour = 1600 cycles, minute = 20 cycles, force timeout = 80 cycles
    motor_start_supervision #(.CYCLES_PER_MS(4), .HOUR_MS(400), .MINUTE_MS(5), .FORCE_MS(20), .MAX_SLOTS(15)) dut (
        .clock(clock), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .avgCurrent(avgCurrent), .keyPress(keyPress), .timeNow(timeNow),
        .startingOut(startingOut), .runningOut(runningOut), .alarmOut(alarmOut),
        .inhibitOut(inhibitOut), .irq(irq));
    motor_front_model model (.clock(clock), .reset(reset), .target(target), .slow(slow),
        .startingOut(startingOut), .avgCurrent(avgCurrent), .startSeen(startSeen));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic waitCyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Request held until the edge that samples waitrequest low; a hang is left to the cycle ceiling
    task automatic busAccess(input logic wr, input logic [5:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge clock);
        while (waitrequest !== 1'b0)
            @(posedge clock);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask

    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h00000000;
        keyPress = 1'b0;
        timeNow = 32'h00000000;
        target = 16'h0000;
        slow = 1'b0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);

        busAccess(0, `REG_NOMINAL, 0);
        `CHK("nominal", 32'h00000064, rd)
        busAccess(0, `REG_START_LEVEL, 0);
        `CHK("start level", 32'h00000258, rd)
        busAccess(0, `REG_MAX_STARTS, 0);
        `CHK("max starts", 32'h00000003, rd)
        busAccess(0, `REG_INTERVAL, 0);
        `CHK("interval", 32'h0000000a, rd)
        busAccess(0, `REG_IRQ_ENABLE, 0);
        `CHK("irq enable", 32'h00000000, rd)
        busAccess(0, 6'h30, 0);
        `CHK("unmapped", 32'h00000000, rd)
        busAccess(1, `REG_START_LEVEL, 32'h00000259);
        busAccess(0, `REG_START_LEVEL, 0);
        `CHK("level write", 32'h00000259, rd)
        busAccess(1, `REG_START_LEVEL, 32'h00000258);
        busAccess(0, `REG_STATUS, 0);
        `CHK("state reset", 3'h1, rd[2:0])
        busAccess(1, `REG_INTERVAL, 32'h00000002);
        busAccess(1, `REG_IRQ_ENABLE, 32'h0000000f);
        $display("test registers done");

        // Stop hold runs out first, so the slow rise meets an armed start detector
        waitCyc(2000);
        slow <= 1'b1;
        target <= 16'd100;
        waitCyc(1700);
        `CHK("soft running", 1'b1, runningOut)
        `CHK("soft starts seen", 8'h00, startSeen)
        busAccess(0, `REG_STATUS, 0);
        `CHK("soft state", 3'h4, rd[2:0])
        `CHK("soft count", 8'h00, rd[15:8])
        slow <= 1'b0;
        target <= 16'd0;
        waitCyc(8);
        `CHK("soft stop run", 1'b0, runningOut)
        $display("test soft start done");

        waitCyc(2100);
        target <= 16'd700;
        waitCyc(4);
        t3 = cyc;
        `CHK("starting", 1'b1, startingOut)
        `CHK("inhibit after start", 1'b1, inhibitOut)
        `CHK("no alarm yet", 1'b0, alarmOut)
        waitCyc(46);
        busAccess(0, `REG_STATUS, 0);
        `CHK("held starting", 3'h2, rd[2:0])
        `CHK("count one", 8'h01, rd[15:8])
        `CHK("minutes since", 16'h0002, rd[31:16])
        `CHK("interval over", 1'b0, inhibitOut)
        target <= 16'd100;
        waitCyc(8);
        `CHK("run after start", 1'b1, runningOut)
        `CHK("start dropped", 1'b0, startingOut)
        target <= 16'd0;
        waitCyc(8);
        busAccess(0, `REG_STATUS, 0);
        `CHK("stopped again", 3'h1, rd[2:0])
        $display("test normal start done");

        timeNow <= 32'h00c0ffee;
        target <= 16'd700;
        waitCyc(8);
        `CHK("short stop no start", 1'b0, startingOut)
        `CHK("alarm second last", 1'b1, alarmOut)
        target <= 16'd0;
        waitCyc(8);
        target <= 16'd700;
        waitCyc(8);
        `CHK("alarm at max", 1'b0, alarmOut)
        target <= 16'd0;
        waitCyc(100);
        `CHK("inhibit at max", 1'b1, inhibitOut)
        `CHK("one start seen", 8'h01, startSeen)
        busAccess(0, `REG_TOTAL, 0);
        `CHK("total", 32'h00000003, rd)
        busAccess(0, `REG_TRIP_TIME, 0);
        `CHK("trip time", 32'h00c0ffee, rd)
        busAccess(0, `REG_TRIP_REC, 0);
        `CHK("trip record", 32'h00000002, rd)
        busAccess(0, `REG_IRQ_STATUS, 0);
        `CHK("events", 32'h0000000f, rd)
        `CHK("irq up", 1'b1, irq)
        busAccess(1, `REG_IRQ_CLEAR, 32'h0000000f);
        busAccess(1, `REG_IRQ_ENABLE, 32'h00000008);
        busAccess(0, `REG_IRQ_STATUS, 0);
        `CHK("events cleared", 32'h00000000, rd)
        `CHK("irq down", 1'b0, irq)
        $display("test frequent start done");

        keyPress <= 1'b1;
        @(posedge clock);
        keyPress <= 1'b0;
        busAccess(1, `REG_CTRL, 32'h0000000b);
        waitCyc(4);
        `CHK("forced start", 1'b1, startingOut)
        `CHK("forced run", 1'b0, runningOut)
        `CHK("forced alarm", 1'b1, alarmOut)
        `CHK("forced inhibit", 1'b0, inhibitOut)
        waitCyc(50);
        `CHK("still forced", 1'b1, startingOut)
        waitCyc(45);
        `CHK("force expired", 1'b0, startingOut)
        `CHK("true inhibit back", 1'b1, inhibitOut)
        $display("test force done");

        // Only the oldest start has aged out in this window; the other two are 72 and 88 cycles younger
        while (cyc < t3 + 1630) @(posedge clock);
        busAccess(0, `REG_STATUS, 0);
        `CHK("slid count", 8'h02, rd[15:8])
        `CHK("inhibit released", 1'b0, inhibitOut)
        `CHK("alarm again", 1'b1, alarmOut)
        `CHK("status flags", 2'b01, rd[4:3])
        `CHK("irq enabled event", 1'b1, irq)
        waitCyc(400);
        busAccess(0, `REG_STATUS, 0);
        `CHK("count empty", 8'h00, rd[15:8])
        `CHK("alarm hour over", 1'b0, alarmOut)
        $display("test hour window done");
        summarize();
    end
endmodule
